// >>> verilog/fsw_pkg.sv
package fsw_pkg;

   // Status byte layout and reset value
   localparam int          STATUS_W        = 8;
   localparam int          BUSY_BIT        = 0;
   localparam int          WEL_BIT         = 1;
   localparam int          PROTECT_LO_BIT  = 2;
   localparam int          PROTECT_HI_BIT  = 5;
   localparam int          QUAD_BIT        = 6;
   localparam int          WRITE_DIS_BIT   = 7;
   localparam logic [7:0]  STATUS_RESET    = 8'h00;

   // Instruction codes
   localparam logic [7:0] SET_WRITE_LATCH_CMD    = 8'h06;
   localparam logic [7:0] CLEAR_WRITE_LATCH_CMD  = 8'h04;
   localparam logic [7:0] STATUS_WRITE_CMD       = 8'h01;
   localparam logic [7:0] READ_STATUS_CMD        = 8'h05;
   localparam logic [7:0] READ_FUNC_CMD          = 8'h48;
   localparam logic [7:0] SUSPEND_CMD            = 8'h75;
   localparam logic [7:0] RESET_ENABLE_CMD       = 8'h66;
   localparam logic [7:0] RESET_CMD              = 8'h99;
   localparam logic [7:0] FULL_ARRAY_ERASE_CMD_A = 8'hC7;
   localparam logic [7:0] FULL_ARRAY_ERASE_CMD_B = 8'h60;
   localparam logic [7:0] GANG_LOCK_CMD          = 8'h7E;
   localparam logic [7:0] GANG_UNLOCK_CMD        = 8'h98;

   // Frame shape
   localparam logic [2:0] OPCODE_ONLY_BYTES = 3'h1;
   localparam logic [2:0] STATUS_WR_BYTES   = 3'h2;
   localparam logic [2:0] ADDR_CMD_BYTES    = 3'h4;
   localparam logic [2:0] BYTE_COUNT_MAX    = 3'h7;

   // Non-volatile status update time
   localparam int SYS_CLK_NS      = 25;
   localparam int SR_WRITE_NS     = 5000;
   localparam int SR_WRITE_CYCLES = (SR_WRITE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

   localparam int NUM_BLOCKS = 256;

   typedef enum logic [1:0] {
      FSW_IDLE      = 2'b00,
      FSW_SR_UPDATE = 2'b01,
      FSW_ENGINE    = 2'b10
   } fsw_state_e;

   // Addressed program and erase instructions
   function automatic logic fsw_is_addr_write(input logic [7:0] op);
      unique case (op)
         8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E,
         8'hD7, 8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

endpackage

// >>> verilog/fsw_link_if.sv
interface fsw_link_if;
   logic [7:0]  op;
   logic [23:0] arg;
   logic [2:0]  bitpos;
   logic [2:0]  nbytes;
   logic        frame_tog;
   logic [7:0]  stat_pub;

   modport link (output op, arg, bitpos, nbytes, frame_tog,
                 input  stat_pub);
   modport core (input  op, arg, bitpos, nbytes, frame_tog,
                 output stat_pub);
endinterface

// >>> verilog/fsw_protect.sv
module fsw_protect
   import fsw_pkg::*;
#(
   parameter int NBLK = NUM_BLOCKS
) (
   // Protect setting and target
   input  wire logic [3:0] bp,
   input  wire logic [7:0] block,
   // Verdict
   output logic            hit
);
   logic [8:0] span;
   logic [8:0] first_prot;

   // Top-anchored area doubling per step; codes above 8 cover all
   always_comb begin
      span       = (bp == 4'h0) ? 9'h000 : 9'(9'h001 << (bp - 4'h1));
      first_prot = 9'(NBLK) - span;
      hit        = (bp != 4'h0) &&
                   ((bp > 4'h8) || ({1'b0, block} >= first_prot));
   end
endmodule

// >>> verilog/fsw_spi_link.sv
module fsw_spi_link
   import fsw_pkg::*;
(
   // Link pins
   input  wire logic  sck,
   input  wire logic  cs_n,
   input  wire logic  si,
   input  wire logic  rst_n,
   output logic       so_out,
   output logic       so_oe_n,
   // Core side
   fsw_link_if.link   lk
);
   logic       lk_idle;
   logic       in_frame;
   logic [6:0] shift;
   logic [6:0] next_shift;
   logic [7:0] next_op;
   logic [23:0] next_arg;
   logic [2:0] next_bitpos;
   logic [2:0] next_nbytes;
   logic       next_frame_tog;
   logic [7:0] stat_copy;
   logic [7:0] next_stat_copy;
   logic       drive;

   // Frame state dies with chip select, without needing a clock edge
   assign lk_idle = cs_n | ~rst_n;

   always_ff @(posedge sck or posedge lk_idle) begin
      if (lk_idle) in_frame <= 1'b0;
      else         in_frame <= 1'b1;
   end

   always_comb begin
      next_shift     = {shift[5:0], si};
      next_op        = lk.op;
      next_arg       = lk.arg;
      next_bitpos    = lk.bitpos + 3'h1;
      next_nbytes    = lk.nbytes;
      next_frame_tog = lk.frame_tog;
      if (!in_frame) begin
         next_shift     = {6'h00, si};
         next_bitpos    = 3'h1;
         next_nbytes    = 3'h0;
         next_frame_tog = ~lk.frame_tog;
      end else begin
         if (lk.nbytes >= 3'h1 && lk.nbytes <= 3'h3)
            next_arg = {lk.arg[22:0], si};
         if (lk.bitpos == 3'h7) begin
            if (lk.nbytes == 3'h0)
               next_op = {shift, si};
            if (lk.nbytes != BYTE_COUNT_MAX)
               next_nbytes = lk.nbytes + 3'h1;
         end
      end
      // One snapshot per frame, with the opcode; core copy is frozen then
      next_stat_copy = stat_copy;
      if (in_frame && (lk.bitpos == 3'h7) && (lk.nbytes == 3'h0)) begin
         next_stat_copy = lk.stat_pub;
      end
   end

   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         shift        <= 7'h00;
         lk.op        <= 8'h00;
         lk.arg       <= 24'h000000;
         lk.bitpos    <= 3'h0;
         lk.nbytes    <= 3'h0;
         lk.frame_tog <= 1'b0;
         stat_copy    <= STATUS_RESET;
      end else begin
         shift        <= next_shift;
         lk.op        <= next_op;
         lk.arg       <= next_arg;
         lk.bitpos    <= next_bitpos;
         lk.nbytes    <= next_nbytes;
         lk.frame_tog <= next_frame_tog;
         stat_copy    <= next_stat_copy;
      end
   end

   // Same byte repeats until chip select rises
   assign drive = in_frame && (lk.nbytes != 3'h0) &&
                  (lk.op == READ_STATUS_CMD || lk.op == READ_FUNC_CMD);

   always_ff @(negedge sck or posedge lk_idle) begin
      if (lk_idle) begin
         so_out  <= 1'b0;
         so_oe_n <= 1'b1;
      end else begin
         so_oe_n <= ~drive;
         so_out  <= drive && (lk.op == READ_STATUS_CMD) &&
                    stat_copy[~lk.bitpos];
      end
   end
endmodule

// >>> verilog/fsw_status_wel.sv
// Function
// - Repeated status byte until chip select rises
// - Status byte layout, busy at bit zero
// - Every status bit resets to zero
// - Busy reads one during internal write
// - Write latch reads one when write enabled
// - Four protect bits, writable, protect blocks
// - Quad enable writable, defaults off
// - Write-disable bit writable, protects status
// - Latch sets only via the set-latch command
// - Status write updates protect, quad, disable
// - Busy throughout program, erase, register writes
// - While busy, only reads, suspend and resets accepted
// - Suspend accepted during program or erase
// - Busy clears on completion regardless outcome
// - Write-class commands need latch set
// - Set-latch command sets the latch
// - Clear-latch command clears the latch
// - Latch clears after write operations finish
// - Write-disable plus protect pin locks status
// - Refuse program/erase into protected area
// - Full erase only with protect bits zero
// - Quad enable repurposes the protect pin
module fsw_status_wel
   import fsw_pkg::*;
#(
   parameter int SR_CYCLES = SR_WRITE_CYCLES,
   parameter int NBLK      = NUM_BLOCKS
) (
   // System clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   // Serial link
   input  wire logic        SCK,
   input  wire logic        CS_N,
   input  wire logic        SI,
   output logic             SO_OUT,
   output logic             SO_OE_N,
   // Protect pin
   input  wire logic        WP_N,
   // Array engine
   output logic             OP_START,
   output logic [7:0]       OP_CODE,
   output logic [23:0]      OP_ADDR,
   output logic             OP_SUSPEND,
   output logic             OP_RESET,
   input  wire logic        OP_DONE,
   // Status view
   output logic [7:0]       STATUS_FLAGS,
   output logic             DATA_LINES_QUAD
);
   fsw_link_if lk ();

   fsw_spi_link u_link (
      .sck     (SCK),
      .cs_n    (CS_N),
      .si      (SI),
      .rst_n   (RST_N),
      .so_out  (SO_OUT),
      .so_oe_n (SO_OE_N),
      .lk      (lk.link)
   );

   // Pin and crossing synchronisers
   logic cs_s1, cs_s2, cs_s3;
   logic wp_s1, wp_s2;
   logic fr_s1, fr_s2;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         cs_s1  <= 1'b1;
         cs_s2  <= 1'b1;
         cs_s3  <= 1'b1;
         wp_s1  <= 1'b1;
         wp_s2  <= 1'b1;
         fr_s1  <= 1'b0;
         fr_s2  <= 1'b0;
      end else begin
         cs_s1  <= CS_N;
         cs_s2  <= cs_s1;
         cs_s3  <= cs_s2;
         wp_s1  <= WP_N;
         wp_s2  <= wp_s1;
         fr_s1  <= lk.frame_tog;
         fr_s2  <= fr_s1;
      end
   end

   fsw_state_e  state, next_state;
   logic [15:0] cnt, next_cnt;
   logic        wel, next_wel;
   logic [3:0]  bp, next_bp;
   logic        qe, next_qe;
   logic        status_write_disable, next_status_write_disable;
   logic [5:0]  pend, next_pend;
   logic        rst_armed, next_rst_armed;
   logic        frame_seen, next_frame_seen;
   logic        next_op_start, next_op_suspend, next_op_reset;
   logic [7:0]  next_op_code;
   logic [23:0] next_op_addr;
   logic [7:0]  next_stat_pub;

   logic        busy;
   logic [7:0]  status;
   logic        frame_end;
   logic        whole;
   logic        wp_eff;
   logic        hw_lock;
   logic        prot_hit;
   logic        is_full_erase;
   logic        is_gang;

   fsw_protect #(.NBLK(NBLK)) u_prot (
      .bp    (bp),
      .block (lk.arg[23:16]),
      .hit   (prot_hit)
   );

   assign busy   = (state != FSW_IDLE);
   assign status = {status_write_disable, qe, bp, wel, busy};
   // Link registers are quiet once chip select is high and SCK stops
   assign frame_end = cs_s2 && !cs_s3 && (fr_s2 != frame_seen);
   assign whole     = (lk.bitpos == 3'h0);
   // Quad mode turns the protect pin into a data line
   assign wp_eff    = qe ? 1'b1 : wp_s2;
   assign hw_lock   = status_write_disable && !wp_eff;
   assign is_full_erase = (lk.op == FULL_ARRAY_ERASE_CMD_A) ||
                          (lk.op == FULL_ARRAY_ERASE_CMD_B);
   assign is_gang   = (lk.op == GANG_LOCK_CMD) || (lk.op == GANG_UNLOCK_CMD);

   always_comb begin
      next_state      = state;
      next_cnt        = cnt;
      next_wel        = wel;
      next_bp         = bp;
      next_qe         = qe;
      next_status_write_disable       = status_write_disable;
      next_pend       = pend;
      next_rst_armed  = rst_armed;
      next_frame_seen = frame_seen;
      next_op_start   = 1'b0;
      next_op_suspend = 1'b0;
      next_op_reset   = 1'b0;
      next_op_code    = OP_CODE;
      next_op_addr    = OP_ADDR;
      unique case (state)
         FSW_IDLE: begin
         end
         FSW_SR_UPDATE: begin
            if (cnt == 16'h0000) begin
               {next_status_write_disable, next_qe, next_bp} = pend;
               next_wel   = 1'b0;
               next_state = FSW_IDLE;
            end else begin
               next_cnt = cnt - 16'h0001;
            end
         end
         FSW_ENGINE: begin
            if (OP_DONE) begin
               next_wel   = 1'b0;
               next_state = FSW_IDLE;
            end
         end
         default: next_state = FSW_IDLE;
      endcase
      if (frame_end) begin
         next_frame_seen = fr_s2;
         next_rst_armed  = (lk.op == RESET_ENABLE_CMD) && whole &&
                           (lk.nbytes == OPCODE_ONLY_BYTES);
         if ((lk.op == RESET_CMD) && rst_armed && whole &&
             (lk.nbytes == OPCODE_ONLY_BYTES)) begin
            // Reset is honoured even while busy
            next_wel      = 1'b0;
            next_state    = FSW_IDLE;
            next_cnt      = 16'h0000;
            next_op_reset = 1'b1;
         end else if (busy) begin
            if ((lk.op == SUSPEND_CMD) && (state == FSW_ENGINE) && whole)
               next_op_suspend = 1'b1;
            // Anything else is dropped while busy
         end else if (lk.op == SET_WRITE_LATCH_CMD && whole) begin
            next_wel = 1'b1;
         end else if (lk.op == CLEAR_WRITE_LATCH_CMD && whole) begin
            next_wel = 1'b0;
         end else if (lk.op == STATUS_WRITE_CMD) begin
            if (wel && whole && (lk.nbytes == STATUS_WR_BYTES) &&
                !hw_lock) begin
               next_pend  = lk.arg[7:2];
               next_cnt   = 16'(SR_CYCLES - 1);
               next_state = FSW_SR_UPDATE;
            end
         end else if (is_full_erase || is_gang) begin
            if (wel && whole && (lk.nbytes == OPCODE_ONLY_BYTES) &&
                (!is_full_erase || bp == 4'h0)) begin
               next_op_start = 1'b1;
               next_op_code  = lk.op;
               next_state    = FSW_ENGINE;
            end
         end else if (fsw_is_addr_write(lk.op)) begin
            if (wel && whole && (lk.nbytes >= ADDR_CMD_BYTES) &&
                !prot_hit) begin
               next_op_start = 1'b1;
               next_op_code  = lk.op;
               next_op_addr  = lk.arg;
               next_state    = FSW_ENGINE;
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         state      <= FSW_IDLE;
         cnt        <= 16'h0000;
         wel        <= STATUS_RESET[WEL_BIT];
         bp         <= STATUS_RESET[PROTECT_HI_BIT:PROTECT_LO_BIT];
         qe         <= STATUS_RESET[QUAD_BIT];
         status_write_disable       <= STATUS_RESET[WRITE_DIS_BIT];
         pend       <= 6'h00;
         rst_armed  <= 1'b0;
         frame_seen <= 1'b0;
         OP_START   <= 1'b0;
         OP_SUSPEND <= 1'b0;
         OP_RESET   <= 1'b0;
         OP_CODE    <= 8'h00;
         OP_ADDR    <= 24'h000000;
      end else begin
         state      <= next_state;
         cnt        <= next_cnt;
         wel        <= next_wel;
         bp         <= next_bp;
         qe         <= next_qe;
         status_write_disable       <= next_status_write_disable;
         pend       <= next_pend;
         rst_armed  <= next_rst_armed;
         frame_seen <= next_frame_seen;
         OP_START   <= next_op_start;
         OP_SUSPEND <= next_op_suspend;
         OP_RESET   <= next_op_reset;
         OP_CODE    <= next_op_code;
         OP_ADDR    <= next_op_addr;
      end
   end

   // Copy moves only while no frame is seen; link takes it at bit eight
   // Limit: eight SCK periods must outlast three SYS_CLK periods
   always_comb begin
      next_stat_pub = lk.stat_pub;
      if (cs_s2) begin
         next_stat_pub = status;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         lk.stat_pub     <= STATUS_RESET;
         STATUS_FLAGS    <= STATUS_RESET;
         DATA_LINES_QUAD <= 1'b0;
      end else begin
         lk.stat_pub     <= next_stat_pub;
         STATUS_FLAGS    <= status;
         DATA_LINES_QUAD <= qe;
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   chk_start_needs_latch: assert property (
      $rose(OP_START) |-> $past(wel))
      else $error("engine started without write latch");
   chk_start_sets_busy: assert property (
      OP_START |-> busy && state == FSW_ENGINE)
      else $error("engine start without busy");
   chk_done_clears: assert property (
      (state == FSW_ENGINE && OP_DONE) |=> !busy && !wel)
      else $error("busy or latch left after completion");
   chk_full_erase_bp: assert property (
      (OP_START && (OP_CODE == FULL_ARRAY_ERASE_CMD_A ||
                    OP_CODE == FULL_ARRAY_ERASE_CMD_B)) |-> bp == 4'h0)
      else $error("full erase with protect bits set");
   chk_suspend_busy: assert property (
      OP_SUSPEND |-> $past(state) == FSW_ENGINE)
      else $error("suspend outside program or erase");
   chk_sr_busy_hold: assert property (
      $rose(state == FSW_SR_UPDATE) |-> busy [*4])
      else $error("status update not busy");
   chk_wp_lock: assert property (
      ($rose(state == FSW_SR_UPDATE) && $past(state) == FSW_IDLE)
      |-> !$past(hw_lock))
      else $error("status write accepted while locked");
   chk_latch_cause: assert property (
      $rose(wel) |-> $past(frame_end && lk.op == SET_WRITE_LATCH_CMD))
      else $error("write latch set by other command");
   chk_status_view: assert property (
      ##1 STATUS_FLAGS[BUSY_BIT] == $past(busy) &&
      STATUS_FLAGS[WEL_BIT] == $past(wel))
      else $error("status view mismatch");
   chk_pub_frozen: assert property (
      (!cs_s2 && !$past(cs_s2)) |-> $stable(lk.stat_pub))
      else $error("status copy moved during a frame");
   chk_busy_no_start: assert property (
      busy |=> !OP_START)
      else $error("engine started while busy");
endmodule

// >>> dv/fsw_spi_host.sv
module fsw_spi_host (
   // Link pins
   output logic      SCK,
   output logic      CS_N,
   output logic      SI,
   input  wire logic SO
);
   timeunit 1ns;
   timeprecision 100ps;

   // Chip select rises just after time zero: link flops see a clean edge
   initial begin
      SCK  = 1'b0;
      CS_N = 1'b0;
      SI   = 1'b1;
      #1 CS_N = 1'b1;
   end

   // Mode 0; clock stands low outside frames, idle data keeps toggling
   task automatic xfer(input logic [31:0] tx, input int nbits,
                       input int nrd, output logic [15:0] rx);
      rx = 16'h0000;
      #2 CS_N = 1'b0;
      for (int i = 0; i < nbits + nrd; i++) begin
         SI = (i < nbits) ? tx[31 - i] : ~SI;
         #6 SCK = 1'b1;
         if (i >= nbits) rx = {rx[14:0], SO};
         #6 SCK = 1'b0;
      end
      #6 CS_N = 1'b1;
      SI = ~SI;
   endtask
endmodule

// >>> dv/flash_status_write_enable_tb.sv
module flash_status_write_enable_tb;
   import fsw_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int SRC = 40;
   logic        SYS_CLK, RST_N, WP_N, OP_DONE;
   logic        SCK, CS_N, SI, so_pin;
   logic        SO_OUT, SO_OE_N, OP_START, OP_SUSPEND, OP_RESET;
   logic        DATA_LINES_QUAD;
   logic [7:0]  OP_CODE, STATUS_FLAGS, st;
   logic [23:0] OP_ADDR;
   logic [15:0] rx;
   int          errors, cmp_count, n_start, n_susp, n_rst;

   // Undriven output shows a changing pattern, never a stale bit
   assign so_pin = (SO_OE_N === 1'b0) ? SO_OUT : ~SCK;

   fsw_spi_host host (.SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(so_pin));

   fsw_status_wel #(.SR_CYCLES(SRC)) dut (
      .SYS_CLK(SYS_CLK), .RST_N(RST_N), .SCK(SCK), .CS_N(CS_N), .SI(SI),
      .SO_OUT(SO_OUT), .SO_OE_N(SO_OE_N), .WP_N(WP_N),
      .OP_START(OP_START), .OP_CODE(OP_CODE), .OP_ADDR(OP_ADDR),
      .OP_SUSPEND(OP_SUSPEND), .OP_RESET(OP_RESET), .OP_DONE(OP_DONE),
      .STATUS_FLAGS(STATUS_FLAGS), .DATA_LINES_QUAD(DATA_LINES_QUAD));

   initial begin
      SYS_CLK = 1'b0;
      forever #12.5 SYS_CLK = ~SYS_CLK;
   end

   function automatic logic prot_hit(input logic [3:0] bp,
                                     input logic [23:0] a);
      if (bp == 4'h0) return 1'b0;
      if (bp > 4'h8) return 1'b1;
      return int'(a[23:16]) >= 256 - (1 << (int'(bp) - 1));
   endfunction

   task automatic wrap_up();
      $display("Comparisons %0d, errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Gap of 12 cycles lets the end of frame reach the core
   task automatic frame(input logic [31:0] tx, input int nb, input int nr);
      host.xfer(tx, nb, nr, rx);
      n_start = 0;
      n_susp  = 0;
      n_rst   = 0;
      repeat (12) begin
         @(posedge SYS_CLK);
         #1;
         if (OP_START === 1'b1) n_start++;
         if (OP_SUSPEND === 1'b1) n_susp++;
         if (OP_RESET === 1'b1) n_rst++;
      end
   endtask

   task automatic wait_ready();
      int i;
      for (i = 0; i < 200; i++) begin
         @(posedge SYS_CLK);
         #1;
         if (STATUS_FLAGS[0] === 1'b0) break;
      end
      if (i == 200) begin
         chk(STATUS_FLAGS, 8'h00);
         wrap_up();
      end
   endtask

   task automatic done_pulse();
      @(posedge SYS_CLK);
      OP_DONE <= 1'b1;
      @(posedge SYS_CLK);
      OP_DONE <= 1'b0;
      wait_ready();
   endtask

   task automatic set_write_latch_cmd();
      frame({SET_WRITE_LATCH_CMD, 24'h000000}, 8, 0);
   endtask

   task automatic rd_chk();
      frame({READ_STATUS_CMD, 24'h000000}, 8, 16);
      chk(rx, {st, st});
   endtask

   task automatic status_write_cmd(input logic [7:0] v);
      set_write_latch_cmd();
      chk(STATUS_FLAGS, st | 8'h02);
      frame({STATUS_WRITE_CMD, v, 16'h0000}, 16, 0);
      chk(STATUS_FLAGS[0], 1'b1);
      st = {v[7:2], 2'b00};
      wait_ready();
      chk(STATUS_FLAGS, st);
      chk(DATA_LINES_QUAD, st[6]);
      rd_chk();
   endtask

   task automatic prog(input logic [23:0] a);
      set_write_latch_cmd();
      frame({8'h02, a}, 32, 0);
      chk(n_start, prot_hit(st[5:2], a) ? 0 : 1);
   endtask

   initial begin
      errors    = 0;
      cmp_count = 0;
      st        = 8'h00;
      RST_N     = 1'b1;
      WP_N      = 1'b1;
      OP_DONE   = 1'b0;
      void'($urandom(32'hD4F5));
      // Reset falls after time zero so asynchronous link flops see it
      #1 RST_N = 1'b0;
      repeat (16) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      #1;
      chk(STATUS_FLAGS, 8'h00);
      rd_chk();
      frame({STATUS_WRITE_CMD, 8'hFC, 16'h0000}, 16, 0);
      chk(STATUS_FLAGS, 8'h00);
      repeat (6) status_write_cmd(8'($urandom));
      status_write_cmd(8'h84);
      set_write_latch_cmd();
      frame({FULL_ARRAY_ERASE_CMD_A, 24'h000000}, 8, 0);
      chk(n_start, 0);
      prog(24'hFF0010);
      prog(24'h001234);
      chk(OP_CODE, 8'h02);
      chk(OP_ADDR, 24'h001234);
      chk(STATUS_FLAGS, 8'h87);
      frame({CLEAR_WRITE_LATCH_CMD, 24'h000000}, 8, 0);
      chk(STATUS_FLAGS, 8'h87);
      frame({SUSPEND_CMD, 24'h000000}, 8, 0);
      chk(n_susp, 1);
      frame({READ_STATUS_CMD, 24'h000000}, 8, 8);
      chk(rx[7:0], 8'h87);
      done_pulse();
      chk(STATUS_FLAGS, 8'h84);
      frame({8'h02, 24'h000100}, 32, 0);
      chk(n_start, 0);
      // Protect pin passes two sync flops before it counts
      @(posedge SYS_CLK);
      WP_N <= 1'b0;
      repeat (4) @(posedge SYS_CLK);
      set_write_latch_cmd();
      frame({STATUS_WRITE_CMD, 8'h00, 16'h0000}, 16, 0);
      chk(STATUS_FLAGS, 8'h86);
      @(posedge SYS_CLK);
      WP_N <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
      frame({STATUS_WRITE_CMD, 8'h00, 16'h0000}, 16, 0);
      wait_ready();
      st = 8'h00;
      chk(STATUS_FLAGS, st);
      set_write_latch_cmd();
      frame({FULL_ARRAY_ERASE_CMD_B, 24'h000000}, 8, 0);
      chk(n_start, 1);
      chk(OP_CODE, FULL_ARRAY_ERASE_CMD_B);
      done_pulse();
      chk(STATUS_FLAGS, 8'h00);
      set_write_latch_cmd();
      frame({GANG_LOCK_CMD, 24'h000000}, 8, 0);
      chk(n_start, 1);
      chk(OP_CODE, GANG_LOCK_CMD);
      frame({READ_FUNC_CMD, 24'h000000}, 8, 16);
      chk(rx, 16'h0000);
      done_pulse();
      chk(STATUS_FLAGS, 8'h00);
      set_write_latch_cmd();
      frame({STATUS_WRITE_CMD, 8'hFC, 16'h0000}, 12, 0);
      chk(STATUS_FLAGS, 8'h02);
      frame({CLEAR_WRITE_LATCH_CMD, 24'h000000}, 8, 0);
      chk(STATUS_FLAGS, 8'h00);
      frame({RESET_ENABLE_CMD, 24'h000000}, 8, 0);
      frame({RESET_CMD, 24'h000000}, 8, 0);
      chk(n_rst, 1);
      chk(SO_OE_N, 1'b1);
      wrap_up();
   end
endmodule
